// [src/otpb_ctrl.sv]
// OTP access, dual data buffers and error coding sequencer with Avalon-MM registers
`timescale 1ns/1ps
`include "otpb_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - One reserved block acts as OTP: read, program, lock allowed, erase refused.
// - Command 65h selects OTP area; array operations then go there.
// - Cold, warm, hot or core reset leaves OTP access mode.
// - OTP block has 64 pages; 0-9 user, 10-63 manufacturer.
// - OTP load uses ordinary load sequence; block address is ignored.
// - Each OTP user page is programmed only once until the next cold reset, never erased.
// - At power-up, lock word with C sets status bit 6.
// - Program to locked OTP is refused and sets status error bit.
// - OTP lock holds until cold reset; boot then sets it again from the lock word.
// - Two independent data buffers, single buffer during boot load.
// - Address change during load or program fails that operation.
// - Program computes 24-bit main code and 10-bit spare code.
// - Every load, boot included, regenerates, compares, fixes one, detects two.
// - Error status reports none, corrected single, or uncorrectable double.
// - Load places originally stored codes into the buffer spare.
// - Bypass bit 9: no code update, no fix, status left stale.
module otpb_ctrl #(
  parameter int MW    = 256,                  // Main words per sector
  parameter int BLK_W = 10                    // Block address width
) (
  input  wire logic             clock,           // 10 MHz clock
  input  wire logic             rst,             // Cold reset, sync, high
  input  wire logic             warm_rst,        // Warm reset, level, high
  input  wire logic [12:0]      avs_address,     // Byte address
  input  wire logic             avs_read,        // Read request
  input  wire logic             avs_write,       // Write request
  input  wire logic [31:0]      avs_writedata,   // Write data
  output logic      [31:0]      avs_readdata,    // Read data
  output logic                  avs_waitrequest, // Stall
  output logic                  core_re,         // Array word read
  output logic                  core_we,         // Array word write
  output logic                  core_commit,     // Start sense or program
  output logic                  core_pgm,        // Commit is program
  output logic                  core_otp,        // Target OTP block
  output logic [BLK_W-1:0]      core_blk,        // Block
  output logic [5:0]            core_page,       // Page
  output logic [1:0]            core_sec,        // Sector
  output logic [$clog2(MW+`OTPB_SPW+1)-1:0] core_idx, // Word index
  output logic [15:0]           core_wdata,      // Word to array
  input  wire logic [15:0]      core_rdata,      // Word from array
  input  wire logic             core_done,       // Array operation done
  input  wire logic             core_fail        // Array operation failed
);
  localparam int BW = MW + `OTPB_SPW;
  localparam int IW = $clog2(MW) + 4;
  localparam int CW = $clog2(BW + 1);
  localparam int AW = $clog2(2 * BW);

  // Bit-position code: xor of indices of set bits, top bit is parity
  function automatic logic [IW:0] ecc_step(logic [IW:0] acc, logic [IW-5:0] w,
                                           logic [15:0] d);
    logic [IW:0] a;
    a = acc;
    for (int b = 0; b < 16; b++)
      if (d[b])
        a = a ^ {1'b1, w, 4'(b)};
    return a;
  endfunction

  otpb_pkg::otpb_state_t state;
  logic [15:0]      buf_mem [2*BW];
  logic [CW-1:0]    cnt;
  logic [AW-1:0]    op_base;
  logic             boot;
  logic [BLK_W-1:0] blk_sel;
  logic [5:0]       page_sel;
  logic [1:0]       sec_sel;
  logic             buf_sel;
  logic             bypass;
  logic             err;
  logic             otp_mode;
  logic             otp_locked;
  logic [9:0]       otp_used;
  logic             addr_chg;
  otpb_pkg::otpb_ecc_t ecc_main;
  otpb_pkg::otpb_ecc_t ecc_spare;
  logic [IW:0]      macc;
  logic [IW:0]      sacc;
  logic [15:0]      st_lo;
  logic [15:0]      st_hi;
  logic [15:0]      st_sp;
  logic [3:0]       lock_nib;
  logic             rv;
  logic [CW-1:0]    ridx;
  logic [15:0]      next_wdata;
  logic [31:0]      next_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  wire          acc_go   = (avs_read || avs_write) && !avs_waitrequest;
  wire          wr_go    = avs_write && !avs_waitrequest;
  wire          reg_hit  = !avs_address[12];
  wire [2:0]    ridx_bus = avs_address[4:2];
  wire [9:0]    bw_idx   = avs_address[11:2];
  wire          buf_hit  = avs_address[12] && (32'(bw_idx) < 2 * BW);
  wire          cmd_go   = wr_go && reg_hit && ridx_bus == `OTPB_R_CMD;
  wire [7:0]    cmd      = avs_writedata[7:0];
  wire          busy     = state != otpb_pkg::ST_IDLE;
  wire          soft_rst = warm_rst || (cmd_go && (cmd == `OTPB_CMD_CORE_RST ||
                           cmd == `OTPB_CMD_HOT_RST));
  wire          addr_wr  = wr_go && reg_hit && (ridx_bus == `OTPB_R_BLOCK ||
                           ridx_bus == `OTPB_R_PAGE || ridx_bus == `OTPB_R_SECTOR);
  wire          user_pg  = page_sel < `OTPB_USER_PAGES;
  wire          pg_refuse = otp_mode && (otp_locked || !user_pg ||
                            otp_used[page_sel[3:0]]);
  wire          idle_cmd = cmd_go && !busy && !soft_rst;
  wire          start_ld = idle_cmd && cmd == `OTPB_CMD_LOAD;
  wire          start_pg = idle_cmd && cmd == `OTPB_CMD_PROG && !pg_refuse;
  wire          refuse   = idle_cmd && ((cmd == `OTPB_CMD_PROG && pg_refuse) ||
                           (cmd == `OTPB_CMD_ERASE && otp_mode));
  wire [AW-1:0] base     = buf_sel ? AW'(BW) : '0;
  wire [AW-1:0] op_addr  = op_base + AW'(cnt);
  wire          in_main  = 32'(cnt) < MW;
  wire [CW-1:0] sp_off   = cnt - CW'(MW);
  wire [CW-1:0] rsp_off  = ridx - CW'(MW);
  wire [2*IW-1:0] mcode  = {macc[IW-1:0], macc[IW-1:0] ^ {IW{macc[IW]}}};
  wire [9:0]    scode    = {sacc[4:0], sacc[4:0] ^ {5{sacc[IW]}}};
  wire [31:0]   mcode32  = 32'(mcode);
  wire [2*IW-1:0] st_code = (2*IW)'({st_hi, st_lo});
  wire [IW-1:0] dp       = st_code[2*IW-1:IW] ^ mcode[2*IW-1:IW];
  wire [IW-1:0] dpn      = st_code[IW-1:0] ^ mcode[IW-1:0];
  wire [4:0]    sdp      = st_sp[9:5] ^ scode[9:5];
  wire [4:0]    sdpn     = st_sp[4:0] ^ scode[4:0];
  wire          eval_go  = state == otpb_pkg::ST_EVAL && !rv;
  wire          m_one    = (dp ^ dpn) == {IW{1'b1}};
  wire          s_one    = (sdp ^ sdpn) == 5'h1f;
  wire          fix_m    = eval_go && !bypass && m_one;
  wire          fix_s    = eval_go && !bypass && s_one;
  wire [AW-1:0] fix_m_a  = op_base + AW'(dp[IW-1:4]);
  wire [AW-1:0] fix_s_a  = op_base + AW'(MW + `OTPB_SP_PROT0) + AW'(sdp[4]);

  ////////////////////////////////////////////////////////////////////////////////
  // Word sent to the array; codes replace spare code words
  always_comb
  begin
    next_wdata = buf_mem[op_addr];
    if (!in_main)
    begin
      case (sp_off)
        CW'(`OTPB_SP_ECC_LO): next_wdata = bypass ? 16'hffff : mcode32[15:0];
        CW'(`OTPB_SP_ECC_HI): next_wdata = bypass ? 16'hffff : mcode32[31:16];
        CW'(`OTPB_SP_ECC_SP): next_wdata = bypass ? 16'hffff : {6'h00, scode};
        default:              next_wdata = buf_mem[op_addr];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state       <= otpb_pkg::ST_BOOT;
      cnt         <= '0;
      op_base     <= '0;
      boot        <= 1'b0;
      core_re     <= 1'b0;
      core_we     <= 1'b0;
      core_commit <= 1'b0;
      core_pgm    <= 1'b0;
      core_otp    <= 1'b0;
      core_blk    <= '0;
      core_page   <= '0;
      core_sec    <= '0;
      core_idx    <= '0;
      core_wdata  <= '0;
    end
    else
    begin
      core_commit <= 1'b0;
      core_re     <= 1'b0;
      core_we     <= 1'b0;
      if (soft_rst)
      begin
        state <= otpb_pkg::ST_IDLE;
        boot  <= 1'b0;
      end
      else
      begin
        case (state)
          otpb_pkg::ST_BOOT:
          begin
            // Boot scan uses buffer 0 only, reads the lock word with coding on
            boot        <= 1'b1;
            core_otp    <= 1'b1;
            core_blk    <= '0;
            core_page   <= '0;
            core_sec    <= '0;
            op_base     <= '0;
            core_pgm    <= 1'b0;
            core_commit <= 1'b1;
            state       <= otpb_pkg::ST_SENSE;
          end
          otpb_pkg::ST_IDLE:
            if (start_ld || start_pg)
            begin
              core_otp    <= otp_mode;
              core_blk    <= otp_mode ? '0 : blk_sel;
              core_page   <= page_sel;
              core_sec    <= sec_sel;
              op_base     <= base;
              cnt         <= '0;
              core_pgm    <= start_pg;
              core_commit <= start_ld;
              state       <= start_pg ? otpb_pkg::ST_WR : otpb_pkg::ST_SENSE;
            end
          otpb_pkg::ST_SENSE:
            if (core_done)
            begin
              cnt   <= '0;
              state <= otpb_pkg::ST_RD;
            end
          otpb_pkg::ST_RD:
            if (cnt != CW'(BW))
            begin
              core_re  <= 1'b1;
              core_idx <= cnt;
              cnt      <= cnt + 1'b1;
            end
            else
              state <= otpb_pkg::ST_EVAL;
          otpb_pkg::ST_EVAL:
            if (!rv)
            begin
              boot  <= 1'b0;
              state <= otpb_pkg::ST_IDLE;
            end
          otpb_pkg::ST_WR:
            if (cnt != CW'(BW))
            begin
              core_we    <= 1'b1;
              core_idx   <= cnt;
              core_wdata <= next_wdata;
              cnt        <= cnt + 1'b1;
            end
            else
            begin
              core_commit <= 1'b1;
              state       <= otpb_pkg::ST_PROG;
            end
          otpb_pkg::ST_PROG:
            if (core_done)
              state <= otpb_pkg::ST_IDLE;
          default: state <= otpb_pkg::ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Code accumulation and capture of stored codes
  always_ff @(posedge clock)
  begin
    if (rst || state == otpb_pkg::ST_IDLE || state == otpb_pkg::ST_SENSE)
    begin
      macc <= '0;
      sacc <= '0;
    end
    else if (state == otpb_pkg::ST_WR && cnt != CW'(BW))
    begin
      if (in_main)
        macc <= ecc_step(macc, cnt[IW-5:0], next_wdata);
      else if (sp_off == CW'(1) || sp_off == CW'(2))
        sacc <= ecc_step(sacc, (IW-4)'(sp_off - CW'(1)), next_wdata);
    end
    else if (rv)
    begin
      if (32'(ridx) < MW)
        macc <= ecc_step(macc, ridx[IW-5:0], core_rdata);
      else if (rsp_off == CW'(1) || rsp_off == CW'(2))
        sacc <= ecc_step(sacc, (IW-4)'(rsp_off - CW'(1)), core_rdata);
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rv       <= 1'b0;
      ridx     <= '0;
      st_lo    <= '0;
      st_hi    <= '0;
      st_sp    <= '0;
      lock_nib <= '0;
    end
    else
    begin
      rv   <= core_re && !soft_rst;
      ridx <= core_idx;
      if (rv && rsp_off == CW'(`OTPB_SP_ECC_LO))
        st_lo <= core_rdata;
      if (rv && rsp_off == CW'(`OTPB_SP_ECC_HI))
        st_hi <= core_rdata;
      if (rv && rsp_off == CW'(`OTPB_SP_ECC_SP))
        st_sp <= core_rdata;
      if (rv && rsp_off == CW'(`OTPB_SP_LOCK))
        lock_nib <= core_rdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data buffers; the stored code words land unchanged in the spare
  always_ff @(posedge clock)
  begin
    if (wr_go && buf_hit)
      buf_mem[AW'(bw_idx)] <= avs_writedata[15:0];
    if (rv)
      buf_mem[op_base + AW'(ridx)] <= core_rdata;
    if (fix_m)
      buf_mem[fix_m_a] <= buf_mem[fix_m_a] ^ (16'h0001 << dp[3:0]);
    if (fix_s)
      buf_mem[fix_s_a] <= buf_mem[fix_s_a] ^ (16'h0001 << sdp[3:0]);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Host registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      blk_sel  <= '0;
      page_sel <= '0;
      sec_sel  <= '0;
      buf_sel  <= 1'b0;
      bypass   <= 1'b0;
    end
    else if (wr_go && reg_hit)
    begin
      case (ridx_bus)
        `OTPB_R_BLOCK:  blk_sel  <= avs_writedata[BLK_W-1:0];
        `OTPB_R_PAGE:   page_sel <= avs_writedata[5:0];
        `OTPB_R_SECTOR: sec_sel  <= avs_writedata[1:0];
        `OTPB_R_BUFSEL: buf_sel  <= avs_writedata[0];
        `OTPB_R_SYSCFG: bypass   <= avs_writedata[`OTPB_BIT_BYPASS];
        default:        bypass   <= bypass;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status: later assignments win, so a set beats a clear in the same cycle, except otp_mode, where a reset beats command 65h
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      err        <= 1'b0;
      otp_mode   <= 1'b0;
      otp_locked <= 1'b0;
      otp_used   <= '0;
      addr_chg   <= 1'b0;
      ecc_main   <= otpb_pkg::ECC_NONE;
      ecc_spare  <= otpb_pkg::ECC_NONE;
    end
    else
    begin
      if (soft_rst)
        otp_mode <= 1'b0;
      else if (idle_cmd && cmd == `OTPB_CMD_OTP)
        otp_mode <= 1'b1;
      if (start_ld || start_pg)
      begin
        err      <= 1'b0;
        addr_chg <= 1'b0;
      end
      if (busy && addr_wr)
        addr_chg <= 1'b1;
      if (refuse)
        err <= 1'b1;
      if (state == otpb_pkg::ST_SENSE && core_done && core_fail)
        err <= 1'b1;
      if (eval_go && addr_chg)
        err <= 1'b1;
      if (state == otpb_pkg::ST_PROG && core_done)
      begin
        if (core_fail || addr_chg)
          err <= 1'b1;
        else if (core_otp && core_page < `OTPB_USER_PAGES)
          otp_used[core_page[3:0]] <= 1'b1;
      end
      if (eval_go && boot && lock_nib == `OTPB_LOCK_NIB)
        otp_locked <= 1'b1;
      if (eval_go && !bypass)
      begin
        ecc_main  <= (dp == '0 && dpn == '0) ? otpb_pkg::ECC_NONE :
                     m_one ? otpb_pkg::ECC_FIXED : otpb_pkg::ECC_UNCORR;
        ecc_spare <= (sdp == '0 && sdpn == '0) ? otpb_pkg::ECC_NONE :
                     s_one ? otpb_pkg::ECC_FIXED : otpb_pkg::ECC_UNCORR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait state, write lands at the edge waitrequest is low
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (buf_hit)
      next_rdata = {16'h0000, buf_mem[AW'(bw_idx)]};
    else if (reg_hit)
    begin
      case (ridx_bus)
        `OTPB_R_BLOCK:  next_rdata = 32'(blk_sel);
        `OTPB_R_PAGE:   next_rdata = 32'(page_sel);
        `OTPB_R_SECTOR: next_rdata = 32'(sec_sel);
        `OTPB_R_BUFSEL: next_rdata = 32'(buf_sel);
        `OTPB_R_STATUS:
        begin
          next_rdata[`OTPB_BIT_BUSY] = busy;
          next_rdata[`OTPB_BIT_ERR]  = err;
          next_rdata[`OTPB_BIT_OTP]  = otp_mode;
          next_rdata[`OTPB_BIT_LOCK] = otp_locked;
        end
        `OTPB_R_SYSCFG: next_rdata[`OTPB_BIT_BYPASS] = bypass;
        `OTPB_R_ECC:    next_rdata = {28'h0000000, ecc_spare, ecc_main};
        default:        next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end
    else
    begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("waitrequest not one cycle");
  a_otp_exit: assert property (soft_rst |=> !otp_mode)
    else $error("OTP mode survived reset");
  a_otp_enter: assert property (idle_cmd && cmd == `OTPB_CMD_OTP |=> otp_mode)
    else $error("OTP command did not enter mode");
  a_lock_refuse: assert property (idle_cmd && cmd == `OTPB_CMD_PROG && otp_mode && otp_locked
    |=> err && !busy ##1 !core_we) else $error("locked OTP programmed");
  a_lock_stays: assert property (otp_locked |=> otp_locked)
    else $error("OTP lock cleared");
  a_erase_refuse: assert property (idle_cmd && cmd == `OTPB_CMD_ERASE && otp_mode
    |=> err) else $error("OTP erase accepted");
  a_mfr_refuse: assert property (idle_cmd && cmd == `OTPB_CMD_PROG && otp_mode
    && !user_pg |=> err && !busy) else $error("manufacturer page programmed");
  a_addr_fail: assert property (state == otpb_pkg::ST_PROG && core_done && addr_chg
    && !soft_rst |=> err) else $error("address change not failed");
  a_bypass_keep: assert property (eval_go && bypass |=> $stable(ecc_main)
    && $stable(ecc_spare)) else $error("bypass updated status");
  a_route_otp: assert property (core_commit && !boot |-> core_otp == otp_mode)
    else $error("OTP routing wrong");
  a_code_word: assert property (core_we && !bypass && core_idx == CW'(MW + `OTPB_SP_ECC_SP)
    |-> core_wdata[9:0] == $past(scode, 1)) else $error("spare code wrong");

  c_boot_done: cover property (boot && eval_go);
  c_fix_main: cover property (fix_m);
  c_prog_otp: cover property (state == otpb_pkg::ST_PROG && core_done && core_otp);
  c_locked: cover property ($rose(otp_locked));
endmodule

// [src/otpb_defs.svh]
// Offsets, field positions, command codes and counts of the OTP buffer controller
`ifndef OTPB_DEFS_SVH
`define OTPB_DEFS_SVH
// Command codes written to the command register
`define OTPB_CMD_OTP      8'h65
`define OTPB_CMD_LOAD     8'h00
`define OTPB_CMD_PROG     8'h80
`define OTPB_CMD_ERASE    8'h94
`define OTPB_CMD_CORE_RST 8'hf0
`define OTPB_CMD_HOT_RST  8'hf3
// Register word index (byte address bits 4:2, bit 12 low)
`define OTPB_R_CMD    3'h0
`define OTPB_R_BLOCK  3'h1
`define OTPB_R_PAGE   3'h2
`define OTPB_R_SECTOR 3'h3
`define OTPB_R_BUFSEL 3'h4
`define OTPB_R_STATUS 3'h5
`define OTPB_R_SYSCFG 3'h6
`define OTPB_R_ECC    3'h7
// Status and configuration bits
`define OTPB_BIT_LOCK   6
`define OTPB_BIT_OTP    7
`define OTPB_BIT_ERR    10
`define OTPB_BIT_BUSY   15
`define OTPB_BIT_BYPASS 9
// Spare layout, in words after the main area
`define OTPB_SPW       8
`define OTPB_SP_PROT0  1
`define OTPB_SP_ECC_LO 3
`define OTPB_SP_ECC_HI 4
`define OTPB_SP_ECC_SP 5
`define OTPB_SP_LOCK   7
`define OTPB_LOCK_NIB  4'hc
`define OTPB_USER_PAGES 6'd10
`define OTPB_OTP_PAGES  64
`endif

// [src/otpb_pkg.sv]
// Types of the OTP buffer controller
package otpb_pkg;
  typedef enum {ST_BOOT, ST_IDLE, ST_SENSE, ST_RD, ST_EVAL, ST_WR, ST_PROG} otpb_state_t;
  typedef enum logic [1:0] {ECC_NONE = 2'h0, ECC_FIXED = 2'h1, ECC_UNCORR = 2'h2} otpb_ecc_t;
endpackage

// [dv/otpb_array_model.sv]
// Behavioural flash array behind the controller's core link
`timescale 1ns/1ps
module otpb_array_model (
  input  wire logic        clock,       // Clock
  input  wire logic        core_re,     // Word read
  input  wire logic        core_we,     // Word write
  input  wire logic        core_commit, // Start op
  input  wire logic        core_pgm,    // Op is program
  input  wire logic        core_otp,    // OTP block
  input  wire logic [9:0]  core_blk,    // Block
  input  wire logic [5:0]  core_page,   // Page
  input  wire logic [8:0]  core_idx,    // Word index
  input  wire logic [15:0] core_wdata,  // Word in
  input  wire logic [7:0]  dly,         // Busy cycles
  output logic      [15:0] core_rdata,  // Word out
  output logic             core_done    // Done pulse
);
  logic [15:0] mem [logic [25:0]];
  logic [15:0] pbuf [0:263];
  logic [25:0] base;
  int          cnt = 0;
  assign base = {core_otp, core_blk, core_page, 9'h0};
  initial
  begin
    core_rdata = 16'ha5a5;
    core_done = 1'b0;
  end
  always @(posedge clock)
  begin
    core_done <= (cnt == 1);
    if (cnt > 0)
      cnt <= cnt - 1;
    // Line keeps moving so a stray sample never matches
    core_rdata <= ~core_rdata;
    if (core_re)
      core_rdata <= mem.exists(base + core_idx) ? mem[base + core_idx] : 16'hffff;
    if (core_we)
      pbuf[core_idx] <= core_wdata;
    if (core_commit)
    begin
      cnt <= dly + 1;
      if (core_pgm)
        for (int i = 0; i < 264; i++)
          mem[26'(base + i)] = (mem.exists(26'(base + i)) ? mem[26'(base + i)] : 16'hffff) & pbuf[i];
    end
  end
endmodule

// [dv/testbench.sv]
// Self-checking bench for the OTP buffer controller
`timescale 1ns/1ps
module testbench;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        warm_rst = 1'b0;
  logic [12:0] avs_address = 13'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, s, q;
  logic        avs_waitrequest, core_re, core_we, core_commit, core_pgm, core_otp, core_done;
  logic [9:0]  core_blk;
  logic [5:0]  core_page;
  logic [1:0]  core_sec;
  logic [8:0]  core_idx;
  logic [15:0] core_wdata, core_rdata;
  logic        core_fail = 1'b0;
  logic [7:0]  dly = 8'h2;
  logic [31:0] seed = 32'h61dc4795;
  logic [15:0] d [0:255];
  logic [15:0] c [3:5];
  int          n_fail = 0;
  int          num_checks = 0;
  localparam logic [12:0] CMD = 13'h0, BLK = 13'h4, PG = 13'h8, SEL = 13'h10, ST = 13'h14;
  otpb_ctrl #(.MW(256), .BLK_W(10)) uut (.clock, .rst, .warm_rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .core_re, .core_we,
    .core_commit, .core_pgm, .core_otp, .core_blk, .core_page, .core_sec, .core_idx,
    .core_wdata, .core_rdata, .core_done, .core_fail);
  otpb_array_model m (.clock, .core_re, .core_we, .core_commit, .core_pgm, .core_otp,
    .core_blk, .core_page, .core_idx, .core_wdata, .dly, .core_rdata, .core_done);
  initial forever #50 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [12:0] ba(input int b, input int k);
    return 13'(32'h1000 + 4 * (b * 264 + k));
  endfunction
  task automatic bus(input logic w, input logic [12:0] a, input logic [31:0] wd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic idle();
    do bus(1'b0, ST, 32'h0); while (q[15] !== 1'b0);
    s = q;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    idle();
    chk(s[7:6], 2'h0);
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, CMD, 32'h65);
      idle();
      chk(s[7], 1'b1);
      warm_rst <= (i == 2);
      bus(1'b1, CMD, (i == 2) ? 32'h0 : (i ? 32'hf3 : 32'hf0));
      warm_rst <= 1'b0;
      idle();
      chk(s[7], 1'b0);
    end
    bus(1'b1, CMD, 32'h65);
    bus(1'b1, CMD, 32'h94);
    idle();
    chk(s[10], 1'b1);
    bus(1'b1, CMD, 32'hf0);
    for (int k = 0; k < 256; k++)
    begin
      s = rnd();
      d[k] = s[15:0];
      bus(1'b1, ba(0, k), {16'h0, d[k]});
    end
    bus(1'b1, BLK, 32'h1);
    // Pass 1 one flip, pass 2 two flips, pass 3 bypass with one flip
    for (int f = 0; f < 4; f++)
    begin
      dly <= 8'(rnd() % 9);
      bus(1'b1, 13'h18, (f == 3) ? 32'h200 : 32'h0);
      bus(1'b1, PG, 32'(f + 3));
      bus(1'b1, SEL, 32'h0);
      bus(1'b1, CMD, 32'h80);
      bus(1'b1, ba(1, 1), 32'h0);
      idle();
      if (f > 0)
        m.mem[{1'b0, 10'd1, 6'(f + 3), 9'd5}] ^= (f == 2) ? 16'h0110 : 16'h0010;
      bus(1'b1, SEL, 32'h1);
      bus(1'b1, CMD, 32'h0);
      idle();
      bus(1'b0, 13'h1c, 32'h0);
      chk(q[1:0], (f == 3) ? 2'h2 : 2'(f));
      chk(q[3:2], 2'h0);
      for (int k = 0; k < 262; k++)
      begin
        bus(1'b0, ba(1, k), 32'h0);
        if (k < 256)
          chk(q, {16'h0, d[k] ^ ((k == 5 && f > 1) ? ((f == 2) ? 16'h0110 : 16'h0010)
            : 16'h0)});
        if (k > 258 && f == 0)
          c[k - 256] = q[15:0];
        else if (k > 258)
          chk(q[15:0], (f == 3) ? 16'hffff : c[k - 256]);
      end
    end
    bus(1'b1, 13'h18, 32'h0);
    dly <= 8'd80;
    bus(1'b1, CMD, 32'h0);
    bus(1'b0, ba(0, 7), 32'h0);
    chk(q, {16'h0, d[7]});
    bus(1'b1, PG, 32'h8);
    idle();
    chk(s[10], 1'b1);
    dly <= 8'd3;
    bus(1'b1, CMD, 32'h65);
    bus(1'b1, SEL, 32'h0);
    bus(1'b1, PG, 32'ha);
    bus(1'b1, CMD, 32'h80);
    idle();
    chk(s[10], 1'b1);
    chk(m.mem.exists({1'b1, 10'd0, 6'd10, 9'd0}), 1'b0);
    for (int j = 0; j < 2; j++)
    begin
      bus(1'b1, ba(0, 0), j ? 32'h0 : 32'h1234);
      bus(1'b1, PG, 32'h1);
      bus(1'b1, CMD, 32'h80);
      idle();
    end
    chk(m.mem[{1'b1, 10'd0, 6'd1, 9'd0}], 16'h1234);
    bus(1'b1, BLK, rnd() & 32'h3ff);
    bus(1'b1, SEL, 32'h1);
    bus(1'b1, CMD, 32'h0);
    idle();
    bus(1'b0, ba(1, 0), 32'h0);
    chk(q, 32'h1234);
    bus(1'b1, SEL, 32'h0);
    bus(1'b1, ba(0, 263), 32'h7ffc);
    bus(1'b1, PG, 32'h0);
    bus(1'b1, CMD, 32'h80);
    idle();
    for (int j = 0; j < 2; j++)
    begin
      rst <= 1'b1;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      idle();
      chk(s[6], 1'b1);
      chk(s[7], 1'b0);
      bus(1'b1, CMD, 32'h65);
      bus(1'b1, PG, 32'h2);
      bus(1'b1, CMD, 32'h80);
      idle();
      chk(s[10], 1'b1);
    end
    chk(m.mem.exists({1'b1, 10'd0, 6'd2, 9'd0}), 1'b0);
    conclude();
  end
  initial
  begin
    #(100 * 60000);
    n_fail++;
    conclude();
  end
endmodule
